// ===== hw/usdb_consts.svh
/*
  constants of the shadow data buffer: register byte addresses, field positions, sizes.
  assumes nothing; included by the package and the design files.
*/
`ifndef USDB_CONSTS_SVH
`define USDB_CONSTS_SVH

`define USDB_SHADOW_BASE 32'h50001130
`define USDB_SHADOW_14 32'h50001168
`define USDB_SHADOW_15 32'h5000116C
`define USDB_SHADOW_LAST 32'h5000116C
`define USDB_LINE_STATUS 32'h500011A0
`define USDB_CTRL 32'h500011A4
`define USDB_IRQ_STAT 32'h500011A8
`define USDB_IRQ_EN 32'h500011AC
`define USDB_IRQ_CLR 32'h500011B0
`define USDB_LEVELS 32'h500011B4

`define USDB_DATA_W 8
`define USDB_PTR_W 4
`define USDB_CNT_W 5
`define USDB_FIFO_DEPTH 5'h10
`define USDB_MEM_WORDS 16

`define USDB_LSR_DR_BIT 0
`define USDB_LSR_TX_HOLDING_EMPTY_FLAG_BIT 5
`define USDB_CTRL_FIFO_EN_BIT 0
`define USDB_CTRL_IR_BIT 1
`define USDB_IRQ_W 3
`define USDB_IRQ_OVR_BIT 0
`define USDB_IRQ_RXA_BIT 1
`define USDB_IRQ_TX_HOLDING_EMPTY_FLAG_BIT 2

`endif

// ===== hw/usdb_pkg.sv
/*
  types of the shadow data buffer: transmit states and the state records.
  assumes usdb_consts.svh is on the include path.
*/
`include "usdb_consts.svh"

package usdb_pkg;

  typedef enum logic [1:0] {
    USDB_TX_IDLE = 2'b00,
    USDB_TX_FETCH = 2'b01,
    USDB_TX_SEND = 2'b11
  } usdb_tx_state_type;

  typedef struct packed {
    logic fifo_en;
    logic ir_mode;
    logic [`USDB_DATA_W-1:0] rx_buf;
    logic rx_buf_valid;
    logic [`USDB_PTR_W-1:0] rx_wp;
    logic [`USDB_PTR_W-1:0] rx_rp;
    logic [`USDB_CNT_W-1:0] rx_cnt;
    logic [`USDB_PTR_W-1:0] tx_wp;
    logic [`USDB_PTR_W-1:0] tx_rp;
    logic [`USDB_CNT_W-1:0] tx_cnt;
    logic [`USDB_DATA_W-1:0] transmit_holding_buffer;
    logic thr_full;
    usdb_tx_state_type tx_st;
    logic [`USDB_DATA_W-1:0] tx_data;
    logic tx_ir;
    logic tx_holding_empty_flag_was_low;
    logic [`USDB_IRQ_W-1:0] irq_stat;
    logic [`USDB_IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic rd_mem;
  } usdb_state_type;

  typedef struct packed {
    logic [`USDB_MEM_WORDS-1:0][`USDB_DATA_W-1:0] cells;
    logic [`USDB_DATA_W-1:0] rdata;
  } usdb_mem_state_type;

endpackage

// ===== hw/usdb_byte_mem.sv
/*
  sixteen-byte store with one write port and one registered read port.
  assumes the caller keeps its own pointers; reads return the old word on a same-cycle write.
*/
`timescale 1ns/10ps
`include "usdb_consts.svh"

module usdb_byte_mem (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [`USDB_PTR_W-1:0] i_waddr,
  input wire logic [`USDB_DATA_W-1:0] i_wdata,
  input wire logic [`USDB_PTR_W-1:0] i_raddr,
  output logic [`USDB_DATA_W-1:0] o_rdata
);
  import usdb_pkg::*;

  usdb_mem_state_type q;
  usdb_mem_state_type d;

  always_comb begin
    d = q;
    d.rdata = q.cells[i_raddr];
    if (i_we) begin
      d.cells[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;

endmodule

// ===== hw/usdb_shadow_data_buffer.sv
/*
  shadow data buffer of a uart: sixteen aliased data words, receive and transmit
  paths with optional sixteen-deep fifos, line status flags and a level interrupt.
  assumes a deserializer handing over whole received bytes and a serializer that
  takes a byte on valid and ready; register port per the plain strobe convention.
*/
// Chosen here: strobed register access.
// Operation
// - received byte from serial or infrared input returned in bits 7:0
// - sixteen aliased 32-bit word locations carry the data path
// - read data valid only while the data-ready flag is set
// - without fifo, a new byte overwrites the unread one and flags overrun
// - with fifo, a read returns and pops the head of the receive fifo
// - full receive fifo keeps contents, drops the new byte, flags overrun
// - written byte goes out on the serial or infrared output
// - without fifo, one write clears the holding-empty flag
// - without fifo, a further write replaces the pending character
// - with fifo, sixteen characters accepted before the fifo is full
// - writes to a full transmit fifo are discarded
`timescale 1ns/10ps
`include "usdb_consts.svh"

module usdb_shadow_data_buffer (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [`USDB_DATA_W-1:0] i_sin_byte,
  input wire logic i_sin_valid,
  input wire logic [`USDB_DATA_W-1:0] i_sir_byte,
  input wire logic i_sir_valid,
  output logic [`USDB_DATA_W-1:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_ir,
  input wire logic i_tx_ready,
  output logic o_rx_data_valid_flag,
  output logic o_tx_holding_empty_flag,
  output logic o_irq
);
  import usdb_pkg::*;

  usdb_state_type q;
  usdb_state_type d;

  logic shadow_hit;
  logic rd_shadow;
  logic wr_shadow;
  logic [`USDB_DATA_W-1:0] rx_byte;
  logic rx_arrive;
  logic rx_full;
  logic rx_pop;
  logic rx_push;
  logic tx_full;
  logic tx_push;
  logic tx_pop;
  logic tx_holding_empty_flag;
  logic [`USDB_IRQ_W-1:0] irq_set;
  logic [31:0] rd_word;
  logic [`USDB_DATA_W-1:0] rx_mem_rdata;
  logic [`USDB_DATA_W-1:0] tx_mem_rdata;

  assign shadow_hit = (i_addr >= `USDB_SHADOW_BASE) && (i_addr <= `USDB_SHADOW_LAST) && (i_addr[1:0] == 2'h0);
  assign rd_shadow = i_rd && shadow_hit;
  assign wr_shadow = i_wr && shadow_hit;

  assign rx_byte = q.ir_mode ? i_sir_byte : i_sin_byte;
  assign rx_arrive = q.ir_mode ? i_sir_valid : i_sin_valid;

  assign rx_full = (q.rx_cnt == `USDB_FIFO_DEPTH);
  assign rx_pop = rd_shadow && q.fifo_en && (q.rx_cnt != 5'h00);
  assign rx_push = rx_arrive && q.fifo_en && (!rx_full || rx_pop);

  assign tx_full = (q.tx_cnt == `USDB_FIFO_DEPTH);
  assign tx_push = wr_shadow && q.fifo_en && !tx_full;
  assign tx_pop = (q.tx_st == USDB_TX_IDLE) && q.fifo_en && (q.tx_cnt != 5'h00);

  assign tx_holding_empty_flag = q.fifo_en ? (q.tx_cnt == 5'h00) : !q.thr_full;

  assign irq_set[`USDB_IRQ_OVR_BIT] = rx_arrive &&
    (q.fifo_en ? (rx_full && !rx_pop) : (q.rx_buf_valid && !rd_shadow));
  assign irq_set[`USDB_IRQ_RXA_BIT] = rx_arrive;
  assign irq_set[`USDB_IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag && q.tx_holding_empty_flag_was_low;

  always_comb begin
    rd_word = 32'h00000000;
    if (shadow_hit) begin
      rd_word = {24'h000000, q.rx_buf};
    end else begin
      case (i_addr)
        `USDB_LINE_STATUS: begin
          rd_word = {26'h0000000, tx_holding_empty_flag, 4'h0, o_rx_data_valid_flag};
        end
        `USDB_CTRL: begin
          rd_word = {30'h00000000, q.ir_mode, q.fifo_en};
        end
        `USDB_IRQ_STAT: begin
          rd_word = {29'h00000000, q.irq_stat};
        end
        `USDB_IRQ_EN: begin
          rd_word = {29'h00000000, q.irq_en};
        end
        `USDB_LEVELS: begin
          rd_word = {19'h00000, q.tx_cnt, 3'h0, q.rx_cnt};
        end
        default: begin
          rd_word = 32'h00000000;
        end
      endcase
    end
  end

  always_comb begin
    d = q;
    d.rdata = i_rd ? rd_word : 32'h00000000;
    d.rd_mem = rd_shadow && q.fifo_en;
    d.tx_holding_empty_flag_was_low = !tx_holding_empty_flag;

    if (rx_arrive && !q.fifo_en) begin
      d.rx_buf = rx_byte;
      d.rx_buf_valid = 1'b1;
    end else if (rd_shadow && !q.fifo_en) begin
      d.rx_buf_valid = 1'b0;
    end

    if (rx_push) begin
      d.rx_wp = q.rx_wp + 4'h1;
    end
    if (rx_pop) begin
      d.rx_rp = q.rx_rp + 4'h1;
    end
    d.rx_cnt = q.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};

    if (tx_push) begin
      d.tx_wp = q.tx_wp + 4'h1;
    end
    if (tx_pop) begin
      d.tx_rp = q.tx_rp + 4'h1;
    end
    d.tx_cnt = q.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

    case (q.tx_st)
      USDB_TX_IDLE: begin
        if (tx_pop) begin
          d.tx_st = USDB_TX_FETCH;
        end else if (!q.fifo_en && q.thr_full) begin
          d.tx_data = q.transmit_holding_buffer;
          d.tx_ir = q.ir_mode;
          d.thr_full = 1'b0;
          d.tx_st = USDB_TX_SEND;
        end
      end
      USDB_TX_FETCH: begin
        d.tx_data = tx_mem_rdata;
        d.tx_ir = q.ir_mode;
        d.tx_st = USDB_TX_SEND;
      end
      USDB_TX_SEND: begin
        if (i_tx_ready) begin
          d.tx_st = USDB_TX_IDLE;
        end
      end
      default: begin
        d.tx_st = USDB_TX_IDLE;
      end
    endcase

    if (wr_shadow && !q.fifo_en) begin
      d.transmit_holding_buffer = i_wdata[`USDB_DATA_W-1:0];
      d.thr_full = 1'b1;
    end

    if (i_wr && (i_addr == `USDB_CTRL)) begin
      d.fifo_en = i_wdata[`USDB_CTRL_FIFO_EN_BIT];
      d.ir_mode = i_wdata[`USDB_CTRL_IR_BIT];
      if (i_wdata[`USDB_CTRL_FIFO_EN_BIT] != q.fifo_en) begin
        d.rx_wp = 4'h0;
        d.rx_rp = 4'h0;
        d.rx_cnt = 5'h00;
        d.tx_wp = 4'h0;
        d.tx_rp = 4'h0;
        d.tx_cnt = 5'h00;
        d.thr_full = 1'b0;
        d.rx_buf_valid = 1'b0;
      end
    end
    if (i_wr && (i_addr == `USDB_IRQ_EN)) begin
      d.irq_en = i_wdata[`USDB_IRQ_W-1:0];
    end
    if (i_wr && (i_addr == `USDB_IRQ_CLR)) begin
      d.irq_stat = (q.irq_stat & ~i_wdata[`USDB_IRQ_W-1:0]) | irq_set;
    end else begin
      d.irq_stat = q.irq_stat | irq_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  usdb_byte_mem u_rx_mem (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_we(rx_push),
    .i_waddr(q.rx_wp),
    .i_wdata(rx_byte),
    .i_raddr(q.rx_rp),
    .o_rdata(rx_mem_rdata)
  );

  usdb_byte_mem u_tx_mem (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_we(tx_push),
    .i_waddr(q.tx_wp),
    .i_wdata(i_wdata[`USDB_DATA_W-1:0]),
    .i_raddr(q.tx_rp),
    .o_rdata(tx_mem_rdata)
  );

  assign o_rdata = q.rd_mem ? {24'h000000, rx_mem_rdata} : q.rdata;
  assign o_rx_data_valid_flag = q.fifo_en ? (q.rx_cnt != 5'h00) : q.rx_buf_valid;
  assign o_tx_holding_empty_flag = tx_holding_empty_flag;
  assign o_tx_data = q.tx_data;
  assign o_tx_valid = (q.tx_st == USDB_TX_SEND);
  assign o_tx_ir = q.tx_ir;
  assign o_irq = |(q.irq_stat & q.irq_en);

  AST_UPPER_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    rd_shadow |=> (o_rdata[31:8] == 24'h000000))
    else $error("upper shadow bits not zero");

  AST_NF_READ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rd_shadow && !q.fifo_en) |=> (o_rdata[7:0] == $past(q.rx_buf)))
    else $error("non-fifo read returned wrong byte");

  AST_NF_OVERRUN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rx_arrive && !q.fifo_en && q.rx_buf_valid && !rd_shadow) |=>
    (q.irq_stat[`USDB_IRQ_OVR_BIT] && (q.rx_buf == $past(rx_byte))))
    else $error("overwrite or overrun missing");

  AST_RX_POP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rx_pop && !rx_arrive) |=> (q.rx_cnt == $past(q.rx_cnt) - 5'h01))
    else $error("receive fifo did not pop");

  AST_RX_FULL_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rx_arrive && q.fifo_en && rx_full && !i_rd && !i_wr) |=>
    (rx_full && $stable(q.rx_wp) && q.irq_stat[`USDB_IRQ_OVR_BIT]))
    else $error("full receive fifo changed");

  AST_TX_HOLDING_EMPTY_FLAG_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_shadow && !q.fifo_en) |=> !o_tx_holding_empty_flag)
    else $error("holding empty not cleared");

  AST_TX_PUSH: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_shadow && q.fifo_en && !tx_full && !tx_pop) |=> (q.tx_cnt == $past(q.tx_cnt) + 5'h01))
    else $error("transmit fifo did not accept");

  AST_TX_DROP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_shadow && q.fifo_en && tx_full && (q.tx_st != USDB_TX_IDLE)) |=> (tx_full && $stable(q.tx_wp)))
    else $error("write to full transmit fifo kept");

  AST_TX_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (o_tx_valid && !i_tx_ready) |=> (o_tx_valid && $stable(o_tx_data)))
    else $error("transmit byte dropped before taken");

  AST_NF_SEND: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!q.fifo_en && q.thr_full && (q.tx_st == USDB_TX_IDLE) && !i_wr) |=>
    (o_tx_valid && (o_tx_data == $past(q.transmit_holding_buffer)))[*1] ##1 1'b1)
    else $error("pending character not sent");

  AST_NF_REPLACE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_shadow && !q.fifo_en) |=> (q.thr_full && (q.transmit_holding_buffer == $past(i_wdata[`USDB_DATA_W-1:0]))))
    else $error("pending character not replaced");

  AST_FIFO_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (q.tx_cnt <= `USDB_FIFO_DEPTH) && (q.rx_cnt <= `USDB_FIFO_DEPTH))
    else $error("fifo count beyond depth");

  AST_TX_NOT_EMPTY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_shadow && q.fifo_en && !tx_full) |=> !o_tx_holding_empty_flag)
    else $error("accepted write left holding empty set");

endmodule

// ===== verification/usdb_peer_model.sv
/*
  remote serial peer: feeds received bytes to the block and takes sent ones.
  assumes one clock; the bench calls send and drives i_stall off the edge.
*/
`timescale 1ns/10ps
module usdb_peer_model (
  input wire logic i_clk_sys,
  input wire logic i_stall,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [7:0] o_sin_byte,
  output logic o_sin_valid,
  output logic [7:0] o_sir_byte,
  output logic o_sir_valid
);
  logic [7:0] got_q[$];
  initial begin
    o_sin_byte = 8'h00;
    o_sir_byte = 8'h00;
    o_sin_valid = 1'b0;
    o_sir_valid = 1'b0;
  end
  assign o_tx_ready = ~i_stall;
  always @(posedge i_clk_sys) begin
    if (i_tx_valid && o_tx_ready) begin
      got_q.push_back(i_tx_data);
    end
  end
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge i_clk_sys);
    o_sin_byte <= b;
    o_sir_byte <= b;
    o_sin_valid <= !ir;
    o_sir_valid <= ir;
    @(posedge i_clk_sys);
    o_sin_valid <= 1'b0;
    o_sir_valid <= 1'b0;
    o_sin_byte <= ~b;
    o_sir_byte <= ~b;
    #1;
  endtask
endmodule

// ===== verification/testbench.sv
/*
  self-checking bench of the shadow data buffer with a peer model.
  assumes usdb_consts.svh on the include path and the design compiled first.
*/
`timescale 1ns/10ps
`include "usdb_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b0;
  logic [7:0] sin_b, sir_b, tx_data, b0, b1, b2;
  logic sin_v, sir_v, tx_v, tx_ir, tx_rdy, dr, tx_holding_empty_flag, irq;
  int bad_count = 0;
  int comparisons = 0;
  logic [15:0] seed = 16'hAB97;
  logic [7:0] exp_q[$];
  usdb_shadow_data_buffer dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sin_byte(sin_b), .i_sin_valid(sin_v), .i_sir_byte(sir_b),
    .i_sir_valid(sir_v), .o_tx_data(tx_data), .o_tx_valid(tx_v), .o_tx_ir(tx_ir), .i_tx_ready(tx_rdy),
    .o_rx_data_valid_flag(dr), .o_tx_holding_empty_flag(tx_holding_empty_flag), .o_irq(irq));
  usdb_peer_model peer (.i_clk_sys(clk), .i_stall(stall), .i_tx_data(tx_data), .i_tx_valid(tx_v),
    .o_tx_ready(tx_rdy), .o_sin_byte(sin_b), .o_sin_valid(sin_v), .o_sir_byte(sir_b), .o_sir_valid(sir_v));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] sh(input int i);
    return `USDB_SHADOW_BASE + 32'(4 * i);
  endfunction
  function automatic void rnd(output logic [7:0] b);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    b = seed[7:0];
  endfunction
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    `CHK(v, e)
  endtask
  task automatic wait_valid();
    for (int n = 0; n < 50 && tx_v !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(tx_v, 1'b1)
  endtask
  task automatic chk_sent(input int n);
    for (int k = 0; k < 400 && peer.got_q.size() < n; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK(peer.got_q.size(), n)
    for (int k = 0; k < n && k < peer.got_q.size(); k++) begin
      `CHK(peer.got_q[k], exp_q[k])
    end
    peer.got_q.delete();
    exp_q.delete();
  endtask
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_reg(`USDB_LINE_STATUS, 32'h00000020);
    chk_reg(32'h500011FC, 32'h0);
    wr_reg(`USDB_IRQ_EN, 32'h1);
    rnd(b0);
    peer.send(1'b0, b0);
    rnd(b1);
    peer.send(1'b0, b1);
    `CHK(dr, 1'b1)
    chk_reg(`USDB_IRQ_STAT, 32'h3);
    `CHK(irq, 1'b1)
    chk_reg(sh(14), {24'h0, b1});
    `CHK(dr, 1'b0)
    wr_reg(`USDB_IRQ_CLR, 32'h7);
    `CHK(irq, 1'b0)
    // infrared source only, serial byte ignored
    wr_reg(`USDB_CTRL, 32'h2);
    rnd(b0);
    peer.send(1'b1, b0);
    peer.send(1'b0, ~b0);
    chk_reg(sh(15), {24'h0, b0});
    stall <= 1'b1;
    rnd(b0);
    wr_reg(sh(3), {24'hFFFFFF, b0});
    `CHK(tx_holding_empty_flag, 1'b0)
    wait_valid();
    `CHK(tx_ir, 1'b1)
    `CHK(tx_data, b0)
    `CHK(tx_holding_empty_flag, 1'b1)
    rnd(b1);
    wr_reg(sh(4), {24'h0, b1});
    rnd(b2);
    wr_reg(sh(5), {24'h0, b2});
    exp_q.push_back(b0);
    exp_q.push_back(b2);
    stall <= 1'b0;
    chk_sent(2);
    // fifo transmit filled until refused
    wr_reg(`USDB_CTRL, 32'h1);
    stall <= 1'b1;
    rnd(b0);
    wr_reg(sh(0), {24'h0, b0});
    exp_q.push_back(b0);
    wait_valid();
    `CHK(tx_ir, 1'b0)
    for (int i = 1; i <= 17; i++) begin
      rnd(b0);
      wr_reg(sh(i % 16), {24'h0, b0});
      if (i <= 16) begin
        exp_q.push_back(b0);
      end
    end
    wr_reg(`USDB_IRQ_CLR, 32'h7);
    chk_reg(`USDB_IRQ_STAT, 32'h0);
    chk_reg(`USDB_LEVELS, 32'h00001000);
    `CHK(tx_holding_empty_flag, 1'b0)
    stall <= 1'b0;
    chk_sent(17);
    `CHK(tx_holding_empty_flag, 1'b1)
    chk_reg(`USDB_IRQ_STAT, 32'h4);
    // fifo receive overflow, popped in order
    wr_reg(`USDB_IRQ_CLR, 32'h7);
    for (int i = 0; i < 17; i++) begin
      rnd(b0);
      peer.send(1'b0, b0);
      if (i < 16) begin
        exp_q.push_back(b0);
      end
    end
    chk_reg(`USDB_LEVELS, 32'h00000010);
    rd_reg(`USDB_IRQ_STAT, d);
    `CHK(d[1:0], 2'h3)
    `CHK(dr, 1'b1)
    for (int i = 0; i < 16; i++) begin
      rd_reg(sh((i * 7) % 16), d);
      `CHK(d, {24'h0, exp_q.pop_front()})
    end
    `CHK(dr, 1'b0)
    // mid-run reset returns to defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_reg(`USDB_CTRL, 32'h0);
    chk_reg(`USDB_LINE_STATUS, 32'h00000020);
    chk_reg(`USDB_LEVELS, 32'h0);
    final_report();
  end
endmodule
